// ---- src/tmrb_params.svh ----
`ifndef TMRB_PARAMS_SVH
`define TMRB_PARAMS_SVH

// register byte offsets
`define TMRB_OFF_CTRL_EVEN 8'h00
`define TMRB_OFF_CTRL_ODD 8'h04
`define TMRB_OFF_CNT_EVEN 8'h08
`define TMRB_OFF_CNT_ODD 8'h0c
`define TMRB_OFF_CNT_PAIR 8'h10

// control field positions
`define TMRB_BIT_ENABLE 15
`define TMRB_PS_HI 6
`define TMRB_PS_LO 4
`define TMRB_BIT_PAIR 3
`define TMRB_BIT_SRC 1

// control reset values and writable masks
`define TMRB_CTRL_RESET 16'h0000
`define TMRB_MASK_EVEN 16'h807a
`define TMRB_MASK_ODD 16'h8072

// widths
`define TMRB_HALF_W 16
`define TMRB_ADDR_W 8
`define TMRB_PSC_W 8

`endif

// ---- src/tmrb_pkg.sv ----
`default_nettype none
`include "tmrb_params.svh"

package tmrb_pkg;

    typedef logic [`TMRB_HALF_W-1:0] tmrb_half_t;
    typedef logic [`TMRB_ADDR_W-1:0] tmrb_addr_t;

    // prescale selector encoding, one code per ratio
    typedef enum logic [2:0] {
        TMRB_DIV1 = 3'h0,
        TMRB_DIV2 = 3'h1,
        TMRB_DIV4 = 3'h2,
        TMRB_DIV8 = 3'h3,
        TMRB_DIV16 = 3'h4,
        TMRB_DIV32 = 3'h5,
        TMRB_DIV64 = 3'h6,
        TMRB_DIV256 = 3'h7
    } tmrb_ps_e;

endpackage

`default_nettype wire

// ---- src/tmrb_cnt_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface tmrb_cnt_if;
    import tmrb_pkg::*;
    logic enable;
    logic src_ext;
    tmrb_ps_e ps;
    logic cascade;
    logic carry_in;
    logic ext_in;
    logic wr;
    tmrb_half_t wdata;
    tmrb_half_t count;
    logic carry_out;

    modport ctl (
        output enable, src_ext, ps, cascade, carry_in, ext_in, wr, wdata,
        input count, carry_out
    );
    modport cnt (
        input enable, src_ext, ps, cascade, carry_in, ext_in, wr, wdata,
        output count, carry_out
    );
endinterface

`default_nettype wire

// ---- src/tmrb_half.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmrb_params.svh"

module tmrb_half (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    tmrb_cnt_if.cnt cif
);
    import tmrb_pkg::*;

    logic ext_q;
    logic [`TMRB_PSC_W-1:0] psc_reg;
    logic src_evt;
    logic psc_wrap;
    logic tick;

    // terminal prescaler count for each ratio
    function automatic logic [`TMRB_PSC_W-1:0] psc_limit(input tmrb_ps_e ps);
        case (ps)
            TMRB_DIV1: psc_limit = 8'h00;
            TMRB_DIV2: psc_limit = 8'h01;
            TMRB_DIV4: psc_limit = 8'h03;
            TMRB_DIV8: psc_limit = 8'h07;
            TMRB_DIV16: psc_limit = 8'h0f;
            TMRB_DIV32: psc_limit = 8'h1f;
            TMRB_DIV64: psc_limit = 8'h3f;
            TMRB_DIV256: psc_limit = 8'hff;
            default: psc_limit = 8'h00;
        endcase
    endfunction

    // rising edge of the external count input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
        end else if (ce) begin
            ext_q <= cif.ext_in;
        end
    end

    assign src_evt = cif.src_ext ? (cif.ext_in & ~ext_q) : 1'b1;
    // a count left above a newly lowered limit wraps at once instead of running to overflow
    assign psc_wrap = (psc_reg >= psc_limit(cif.ps));
    // cascaded half counts carries, bypassing its own source and prescaler
    assign tick = cif.enable & (cif.cascade ? cif.carry_in : (src_evt & psc_wrap));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_reg <= 8'h00;
        end else if (ce) begin
            if (!cif.enable || cif.cascade) begin
                psc_reg <= 8'h00;
            end else if (src_evt) begin
                psc_reg <= psc_wrap ? 8'h00 : psc_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cif.count <= '0;
        end else if (ce) begin
            if (cif.wr) begin
                cif.count <= cif.wdata;
            end else if (tick) begin
                cif.count <= cif.count + 16'h0001;
            end
        end
    end

    assign cif.carry_out = tick & (&cif.count) & ~cif.wr;

endmodule // tmrb_half

`default_nettype wire

// ---- src/tmrb_top.sv ----
// Contract
// - With pair mode set on the even timer, even and odd count as one 32-bit counter, else as two 16-bit counters.
// - Only the even timer's control register holds the pair mode bit; the odd one reads it as zero.
// - Count source select at one counts rising edges of the external count input, at zero every clock.
// - In pair mode the odd timer's source select is ignored and the even register configures the whole counter.
// - Control bits 2 and 0 are unimplemented and read as zero.
// - The prescaler divides the selected source by 1, 2, 4, 8, 16, 32, 64 or 256.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmrb_params.svh"

module tmrb_top (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire tmrb_pkg::tmrb_addr_t PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_COUNT_INPUT_EVEN,
    input wire logic EXT_COUNT_INPUT_ODD,
    output logic PAIR_ACTIVE,
    output logic [31:0] COUNT_PAIR
);
    import tmrb_pkg::*;

    tmrb_cnt_if even_if ();
    tmrb_cnt_if odd_if ();

    logic [15:0] ctrl_even_reg;
    logic [15:0] ctrl_odd_reg;
    logic pair_mode_select;
    logic setup_phase;
    logic wr_access;
    logic mapped;
    logic [31:0] rdata_next;

    // decode of mapped offsets
    function automatic logic is_mapped(input tmrb_addr_t a);
        is_mapped = (a == `TMRB_OFF_CTRL_EVEN) || (a == `TMRB_OFF_CTRL_ODD) ||
                    (a == `TMRB_OFF_CNT_EVEN) || (a == `TMRB_OFF_CNT_ODD) ||
                    (a == `TMRB_OFF_CNT_PAIR);
    endfunction

    assign PREADY = CE;
    assign setup_phase = PSEL & ~PENABLE;
    assign wr_access = PSEL & PENABLE & PWRITE & CE;
    assign mapped = is_mapped(PADDR);

    // control registers; unimplemented bits never stored
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_even_reg <= `TMRB_CTRL_RESET;
        end else if (wr_access && PADDR == `TMRB_OFF_CTRL_EVEN) begin
            ctrl_even_reg <= PWDATA[15:0] & `TMRB_MASK_EVEN;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_odd_reg <= `TMRB_CTRL_RESET;
        end else if (wr_access && PADDR == `TMRB_OFF_CTRL_ODD) begin
            ctrl_odd_reg <= PWDATA[15:0] & `TMRB_MASK_ODD;
        end
    end

    assign pair_mode_select = ctrl_even_reg[`TMRB_BIT_PAIR];

    // even half: always configured by its own register
    assign even_if.enable = ctrl_even_reg[`TMRB_BIT_ENABLE];
    assign even_if.src_ext = ctrl_even_reg[`TMRB_BIT_SRC];
    assign even_if.ps = tmrb_ps_e'(ctrl_even_reg[`TMRB_PS_HI:`TMRB_PS_LO]);
    assign even_if.cascade = 1'b0;
    assign even_if.carry_in = 1'b0;
    assign even_if.ext_in = EXT_COUNT_INPUT_EVEN;
    assign even_if.wr = wr_access &&
        (PADDR == `TMRB_OFF_CNT_EVEN || (PADDR == `TMRB_OFF_CNT_PAIR && pair_mode_select));
    assign even_if.wdata = PWDATA[15:0];

    // odd half: in pair mode it takes its enable from the even register and counts the even half's carries
    assign odd_if.enable = pair_mode_select ? ctrl_even_reg[`TMRB_BIT_ENABLE] : ctrl_odd_reg[`TMRB_BIT_ENABLE];
    assign odd_if.src_ext = pair_mode_select ? 1'b0 : ctrl_odd_reg[`TMRB_BIT_SRC];
    assign odd_if.ps = tmrb_ps_e'(ctrl_odd_reg[`TMRB_PS_HI:`TMRB_PS_LO]);
    assign odd_if.cascade = pair_mode_select;
    assign odd_if.carry_in = even_if.carry_out;
    assign odd_if.ext_in = EXT_COUNT_INPUT_ODD;
    assign odd_if.wr = wr_access &&
        (PADDR == `TMRB_OFF_CNT_ODD || (PADDR == `TMRB_OFF_CNT_PAIR && pair_mode_select));
    assign odd_if.wdata = (PADDR == `TMRB_OFF_CNT_PAIR) ? PWDATA[31:16] : PWDATA[15:0];

    tmrb_half u_even (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .cif(even_if.cnt)
    );

    tmrb_half u_odd (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .cif(odd_if.cnt)
    );

    // read mux; pair view reads zero outside pair mode
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (PADDR)
            `TMRB_OFF_CTRL_EVEN: rdata_next = {16'h0000, ctrl_even_reg};
            `TMRB_OFF_CTRL_ODD: rdata_next = {16'h0000, ctrl_odd_reg};
            `TMRB_OFF_CNT_EVEN: rdata_next = {16'h0000, even_if.count};
            `TMRB_OFF_CNT_ODD: rdata_next = {16'h0000, odd_if.count};
            `TMRB_OFF_CNT_PAIR: rdata_next = pair_mode_select ? {odd_if.count, even_if.count} : 32'h0000_0000;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (CE && setup_phase) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PSLVERR <= 1'b0;
        end else if (CE && setup_phase) begin
            PSLVERR <= ~mapped;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PAIR_ACTIVE <= 1'b0;
        end else if (CE) begin
            PAIR_ACTIVE <= pair_mode_select;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_PAIR <= 32'h0000_0000;
        end else if (CE) begin
            COUNT_PAIR <= {odd_if.count, even_if.count};
        end
    end

endmodule // tmrb_top

`default_nettype wire

// ---- verification/tmrb_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmrb_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire tmrb_pkg::tmrb_addr_t PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PAIR_ACTIVE,
    input wire logic [31:0] COUNT_PAIR
);
    import tmrb_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence setup_s;
        PSEL && !PENABLE && CE;
    endsequence
    sequence wr_even_s;
        PSEL && PENABLE && PWRITE && CE && PADDR == 8'h00;
    endsequence
    ready_ce_a: assert property (PREADY == CE) else $error("ready differs from enable");
    ctrl_unimpl_a: assert property (setup_s ##0 !PWRITE && PADDR inside {8'h00, 8'h04} |=>
        !PRDATA[2] && !PRDATA[0] && PRDATA[31:16] == 16'h0) else $error("unused control bits set");
    odd_pair_a: assert property (setup_s ##0 !PWRITE && PADDR == 8'h04 |=> !PRDATA[3])
        else $error("odd pair bit set");
    unmapped_err_a: assert property (setup_s ##0 PADDR > 8'h10 |=> PSLVERR) else $error("no error flag");
    mapped_ok_a: assert property (setup_s ##0 PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10} |=> !PSLVERR)
        else $error("false error flag");
    pair_write_a: assert property (wr_even_s ##1 CE |=> PAIR_ACTIVE == $past(PWDATA[3], 2))
        else $error("pair mode not applied");
    carry_a: assert property (PAIR_ACTIVE && COUNT_PAIR[15:0] == 16'hffff ##1 COUNT_PAIR[15:0] == 16'h0 |->
        COUNT_PAIR[31:16] == $past(COUNT_PAIR[31:16]) + 16'h1) else $error("carry lost");
    freeze_a: assert property (!CE |=> $stable(COUNT_PAIR) && $stable(PAIR_ACTIVE)) else $error("state moved");
    rd_hold_a: assert property (!(PSEL && !PENABLE && CE) |=> $stable(PRDATA)) else $error("read data moved");
endmodule // tmrb_chk
`default_nettype wire

// ---- verification/tmrb_ext_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmrb_ext_src #(parameter int HALF = 3) (
    input wire logic clk,
    input wire logic run,
    output logic ext = 1'b0
);
    int cnt = 0;
    // stands low while not running
    always @(posedge clk) begin
        cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
        if (!run) begin
            ext <= 1'b0;
        end else if (cnt == HALF - 1) begin
            ext <= !ext;
        end
    end
endmodule // tmrb_ext_src
`default_nettype wire

// ---- verification/test_timer_pair_clock_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmrb_params.svh"
module test_timer_pair_clock_select;
    import tmrb_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, run = 0, pready, pslverr, pair_active;
    logic ext_e, ext_o, err;
    tmrb_addr_t paddr = '0;
    logic [31:0] pwdata = '0, prdata, count_pair, rd, v;
    int fails = 0, n_checks = 0, cyc = 0;
    always #50 clk = !clk;
    tmrb_top dut_u (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_COUNT_INPUT_EVEN(ext_e), .EXT_COUNT_INPUT_ODD(ext_o), .PAIR_ACTIVE(pair_active),
        .COUNT_PAIR(count_pair));
    tmrb_ext_src #(.HALF(3)) src_e (.clk(clk), .run(run), .ext(ext_e));
    tmrb_ext_src #(.HALF(5)) src_o (.clk(clk), .run(run), .ext(ext_o));
    function automatic int ratio(input int c);
        return (c == 7) ? 256 : (1 << c);
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task apb(input logic w, input tmrb_addr_t a, input logic [31:0] d);
        // idle cycle before each setup keeps the cycle after an enable clear access-free
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        void'($urandom(84335));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 8'h00, 0);
        chk(rd, `TMRB_CTRL_RESET);
        apb(1, 8'h14, 32'h1);
        chk(err, 1);
        apb(0, 8'h14, 0);
        chk(rd, 0);
        $display("reset and unmapped done");
        repeat (8) begin
            v = $urandom;
            apb(1, 8'h00, v);
            apb(0, 8'h00, 0);
            chk(rd, v & `TMRB_MASK_EVEN);
            apb(1, 8'h04, v);
            apb(0, 8'h04, 0);
            chk(rd, v & `TMRB_MASK_ODD);
        end
        $display("control access done");
        for (int c = 0; c < 8; c++) begin
            apb(1, 8'h00, 32'h8000 | (c << 4));
            apb(1, 8'h08, 0);
            repeat (8 * ratio(c) - 2) @(posedge clk);
            apb(0, 8'h08, 0);
            chk(rd >= 7 && rd <= 10, 1);
        end
        $display("prescaler done");
        run <= 1'b1;
        apb(1, 8'h00, 32'h8002);
        apb(1, 8'h04, 32'h8002);
        apb(1, 8'h08, 0);
        apb(1, 8'h0c, 0);
        repeat (60) @(posedge clk);
        apb(0, 8'h08, 0);
        chk(rd >= 9 && rd <= 12, 1);
        apb(0, 8'h0c, 0);
        chk(rd >= 5 && rd <= 8, 1);
        run <= 1'b0;
        $display("external source done");
        // odd enable left clear, odd source external at divide by 256: pair must still run off the even register
        apb(1, 8'h04, 32'h0072);
        apb(1, 8'h00, 32'h8008);
        apb(1, 8'h10, 32'h0001fff0);
        repeat (30) @(posedge clk);
        apb(0, 8'h0c, 0);
        chk(rd, 2);
        chk(count_pair[31:16], 2);
        chk(pair_active, 1);
        apb(1, 8'h00, 32'h8000);
        apb(0, 8'h10, 0);
        chk(rd, 0);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        v = count_pair;
        repeat (5) @(posedge clk);
        chk(count_pair, v);
        ce <= 1'b1;
        $display("pair mode done");
        results();
    end
endmodule // test_timer_pair_clock_select
bind tmrb_top tmrb_chk chk_u (.CLK_SYS, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .PAIR_ACTIVE, .COUNT_PAIR);
`default_nettype wire
